// File: verilog/decode_pkg.sv
// Shared constants for the swap, exclusive-OR and direction-load decoder
package decode_pkg;
  // -------------------------------------------------------------------
  // Instruction word layout
  // -------------------------------------------------------------------
  localparam int unsigned INSN_W = 12;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned DEST_BIT = 5;
  // Opcode patterns on bits 11:6
  localparam logic [5:0] SWAP_OPC = 6'h0e;   // 0011 10
  localparam logic [5:0] REGXOR_OPC = 6'h06; // 0001 10
  // Literal exclusive-OR on bits 11:8
  localparam logic [3:0] LITXOR_OPC = 4'hf;  // 1111
  // Direction load: bits 11:3 zero
  localparam logic [8:0] DIRLOAD_OPC = 9'h000;
  // Direction register operands
  localparam logic [2:0] DIR_FIRST = 3'h5;
  localparam logic [2:0] DIR_LAST = 3'h7;
  // -------------------------------------------------------------------
  // Values after reset
  // -------------------------------------------------------------------
  localparam logic [7:0] ACC_RESET = 8'h00;
  localparam logic ZERO_RESET = 1'b0;
  localparam logic [7:0] DIR_RESET = 8'hff;
endpackage : decode_pkg

// File: verilog/swap_xor_dirload_decode.sv
// Decode and execute of nibble swap, both exclusive-ORs and direction load
module swap_xor_dirload_decode
(
  // Clock and reset
  input wire logic clk,
  input wire logic reset_n,
  // Instruction from program memory, one word a cycle
  input wire logic insn_valid,
  input wire logic [11:0] insn_word,
  // Read data of the addressed file register (same clock, combinational)
  input wire logic [7:0] file_rdata,
  // File register access
  output logic [4:0] file_addr,
  output logic file_we_reg,
  output logic [4:0] file_waddr_reg,
  output logic [7:0] file_wdata_reg,
  // Core state
  output logic [7:0] acc_reg,
  output logic zero_flag_reg,
  output logic [7:0] dir_a_reg,
  output logic [7:0] dir_b_reg,
  output logic [7:0] dir_c_reg
);
  // -------------------------------------------------------------------
  // Decode
  // -------------------------------------------------------------------
  logic is_swap, is_regxor, is_litxor, is_dir, dest_file;
  logic [7:0] swap_val, regxor_val, litxor_val;

  // Zero test shared by both exclusive-OR paths
  function automatic logic is_zero(input logic [7:0] v);
    is_zero = (v == 8'h00);
  endfunction

  // File address is a plain slice so the register file can answer in time
  assign file_addr = insn_word[4:0];
  assign dest_file = insn_word[decode_pkg::DEST_BIT];
  assign is_swap = insn_valid && insn_word[11:6] == decode_pkg::SWAP_OPC;
  assign is_regxor = insn_valid && insn_word[11:6] == decode_pkg::REGXOR_OPC;
  assign is_litxor = insn_valid && insn_word[11:8] == decode_pkg::LITXOR_OPC;
  // Operands outside 5..7 are ignored rather than trapped
  // The compare is unsigned, so operands 0 to 4 fall below the first one
  assign is_dir = insn_valid && insn_word[11:3] == decode_pkg::DIRLOAD_OPC
    && insn_word[2:0] >= decode_pkg::DIR_FIRST;
  assign swap_val = {file_rdata[3:0], file_rdata[7:4]};
  assign litxor_val = acc_reg ^ insn_word[7:0];
  assign regxor_val = acc_reg ^ file_rdata;

  // -------------------------------------------------------------------
  // Accumulator
  // -------------------------------------------------------------------
  // Each instruction retires on the edge that ends its cycle
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      acc_reg <= decode_pkg::ACC_RESET;
    else if (is_litxor)
      acc_reg <= litxor_val;
    else if (is_swap && !dest_file)
      acc_reg <= swap_val;
    else if (is_regxor && !dest_file)
      acc_reg <= regxor_val;
  end

  // Zero flag: swap and direction load leave it alone
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      zero_flag_reg <= decode_pkg::ZERO_RESET;
    else if (is_litxor)
      zero_flag_reg <= is_zero(litxor_val);
    else if (is_regxor)
      zero_flag_reg <= is_zero(regxor_val);
  end

  // -------------------------------------------------------------------
  // File register write-back
  // -------------------------------------------------------------------
  // Address and data follow every cycle; only the strobe says they count
  // Saves a mux per bit, at the price of idle toggling on the write bus
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      file_we_reg <= 1'b0;
      file_waddr_reg <= 5'h00;
      file_wdata_reg <= 8'h00;
    end
    else
    begin
      file_we_reg <= (is_swap || is_regxor) && dest_file;
      file_waddr_reg <= insn_word[4:0];
      file_wdata_reg <= is_swap ? swap_val : regxor_val;
    end
  end

  // -------------------------------------------------------------------
  // Port direction registers
  // -------------------------------------------------------------------
  // Reset to all inputs so pins do not drive before software decides
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      dir_a_reg <= decode_pkg::DIR_RESET;
      dir_b_reg <= decode_pkg::DIR_RESET;
      dir_c_reg <= decode_pkg::DIR_RESET;
    end
    else if (is_dir)
    begin
      case (insn_word[2:0])
        3'h5: dir_a_reg <= acc_reg;
        3'h6: dir_b_reg <= acc_reg;
        3'h7: dir_c_reg <= acc_reg;
        default: ;
      endcase
    end
  end

  // -------------------------------------------------------------------
  // Checks: accumulator and zero flag
  // -------------------------------------------------------------------
  // Literal path reads the accumulator as it stood before the edge
  a_litxor_result: assert property (@(posedge clk) disable iff (!reset_n)
    is_litxor |=> acc_reg == $past(acc_reg ^ insn_word[7:0]))
    else $error("literal xor result wrong");
  // A zero result must set the flag and any other value must clear it
  a_litxor_zero: assert property (@(posedge clk) disable iff (!reset_n)
    is_litxor |=> zero_flag_reg == (($past(acc_reg) ^ $past(insn_word[7:0])) == 8'h00))
    else $error("zero flag wrong after literal xor");
  // Zero follows the register result whichever destination it went to
  a_zero_tracks: assert property (@(posedge clk) disable iff (!reset_n)
    is_regxor |=> zero_flag_reg == (($past(acc_reg) ^ $past(file_rdata)) == 8'h00))
    else $error("zero flag wrong after register xor");
  // Register result aimed at the accumulator must not also be written back
  a_regxor_acc: assert property (@(posedge clk) disable iff (!reset_n)
    is_regxor && !dest_file |=> acc_reg == ($past(acc_reg) ^ $past(file_rdata)) && !file_we_reg)
    else $error("register xor to accumulator wrong");
  // Register result aimed at the file leaves the accumulator alone
  a_regxor_keep: assert property (@(posedge clk) disable iff (!reset_n)
    is_regxor && dest_file |=> $stable(acc_reg))
    else $error("register xor to file touched accumulator");
  // An empty cycle retires nothing
  a_idle_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !insn_valid |=> $stable(acc_reg) && $stable(zero_flag_reg) && !file_we_reg)
    else $error("state changed without an instruction");

  // -------------------------------------------------------------------
  // Checks: nibble swap
  // -------------------------------------------------------------------
  // Swap is a pure move, so the zero flag must not budge
  a_swap_flags: assert property (@(posedge clk) disable iff (!reset_n)
    is_swap |=> $stable(zero_flag_reg))
    else $error("swap changed zero flag");
  // Destination bit clear: nibbles land in the accumulator only
  a_swap_acc: assert property (@(posedge clk) disable iff (!reset_n)
    is_swap && !dest_file |=> acc_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
      && !file_we_reg)
    else $error("swap to accumulator wrong");
  // Destination bit set: nibbles go back to the register file
  a_swap_file: assert property (@(posedge clk) disable iff (!reset_n)
    is_swap && dest_file |=> file_we_reg && $stable(acc_reg)
      && file_wdata_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])})
    else $error("swap to file wrong");
  // The write lands on the register that was read
  a_swap_addr: assert property (@(posedge clk) disable iff (!reset_n)
    is_swap && dest_file |=> file_waddr_reg == $past(insn_word[4:0]))
    else $error("swap wrote the wrong register");

  // -------------------------------------------------------------------
  // Checks: file write-back
  // -------------------------------------------------------------------
  // Address and data must travel with the strobe
  a_regxor_file: assert property (@(posedge clk) disable iff (!reset_n)
    is_regxor && dest_file |=> file_we_reg && file_wdata_reg == ($past(acc_reg) ^ $past(file_rdata))
      && file_waddr_reg == $past(insn_word[4:0]))
    else $error("register xor to file wrong");
  // A stray strobe would corrupt the register file silently
  a_write_cause: assert property (@(posedge clk) disable iff (!reset_n)
    file_we_reg |-> $past((is_swap || is_regxor) && dest_file))
    else $error("file write without cause");
  // The literal path has no file destination at all
  a_litxor_nowrite: assert property (@(posedge clk) disable iff (!reset_n)
    is_litxor |=> !file_we_reg)
    else $error("literal xor wrote the register file");

  // -------------------------------------------------------------------
  // Checks: direction registers
  // -------------------------------------------------------------------
  // Middle operand loads the second register
  a_dir_load: assert property (@(posedge clk) disable iff (!reset_n)
    is_dir && insn_word[2:0] == 3'h6 |=> dir_b_reg == $past(acc_reg) && $stable(zero_flag_reg))
    else $error("direction load wrong");
  // First operand loads only the first register
  a_dir_first: assert property (@(posedge clk) disable iff (!reset_n)
    is_dir && insn_word[2:0] == 3'h5 |=> dir_a_reg == $past(acc_reg)
      && $stable(dir_b_reg) && $stable(dir_c_reg))
    else $error("first direction load wrong");
  // Last operand loads only the last register
  a_dir_last: assert property (@(posedge clk) disable iff (!reset_n)
    is_dir && insn_word[2:0] == 3'h7 |=> dir_c_reg == $past(acc_reg)
      && $stable(dir_a_reg) && $stable(dir_b_reg))
    else $error("last direction load wrong");
  // Direction load touches neither flags, accumulator nor register file
  a_dir_flags: assert property (@(posedge clk) disable iff (!reset_n)
    is_dir |=> $stable(zero_flag_reg) && $stable(acc_reg) && !file_we_reg)
    else $error("direction load disturbed core state");
  // Operands 0 to 4 in the load pattern must change nothing
  a_dir_refused: assert property (@(posedge clk) disable iff (!reset_n)
    insn_valid && insn_word[11:3] == 9'h000 && insn_word[2:0] < 3'h5
      |=> $stable(dir_a_reg) && $stable(dir_b_reg) && $stable(dir_c_reg))
    else $error("direction register loaded by bad operand");
  // Nothing else may reach the direction registers
  a_dir_quiet: assert property (@(posedge clk) disable iff (!reset_n)
    !is_dir |=> $stable(dir_a_reg) && $stable(dir_b_reg) && $stable(dir_c_reg))
    else $error("direction register changed unasked");
endmodule // swap_xor_dirload_decode

// File: verif/file_reg_model.sv
// Behavioural register file that answers the decoder's file accesses
module file_reg_model
(
  // Clock
  input wire logic clk,
  // Access from the decoder
  input wire logic [4:0] file_addr,
  input wire logic we,
  input wire logic [4:0] waddr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] mem [32];
  // Distinct start value per address, so a wrong address shows up as wrong data
  initial for (int i = 0; i < 32; i++) mem[i] = 8'(i * 37 + 5);
  // Write-back lands one edge after the pulse; the decoder does no forwarding
  always @(posedge clk) if (we) mem[waddr] <= wdata;
  assign rdata = mem[file_addr];
endmodule // file_reg_model

// File: verif/swap_xor_dirload_decode_tb_top.sv
// Self-checking bench of the swap, exclusive-OR and direction-load decoder
module swap_xor_dirload_decode_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic insn_valid = 1'b0;
  logic [11:0] insn_word = 12'h000;
  logic [7:0] rdata, acc, wdata, da, db, dc, ea;
  logic [4:0] addr, waddr;
  logic we, zero, ez;
  logic [7:0] em [32];
  logic [7:0] ks [3] = '{8'hb5, 8'haf, 8'h1a};
  int bad_count = 0;
  int total_checks = 0;
  // 200 MHz clock
  always #2.5 clk = ~clk;
  swap_xor_dirload_decode i_dut (.clk(clk), .reset_n(reset_n), .insn_valid(insn_valid),
    .insn_word(insn_word), .file_rdata(rdata), .file_addr(addr), .file_we_reg(we),
    .file_waddr_reg(waddr), .file_wdata_reg(wdata), .acc_reg(acc), .zero_flag_reg(zero),
    .dir_a_reg(da), .dir_b_reg(db), .dir_c_reg(dc));
  file_reg_model i_mem (.clk(clk), .file_addr(addr), .we(we), .waddr(waddr), .wdata(wdata),
    .rdata(rdata));
  // --------
  // Shared tasks
  // --------
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("Error at %0t ns: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // One instruction for one edge; a spare cycle first lets write-backs commit
  task automatic run(input logic [11:0] w);
    @(negedge clk);
    insn_valid = 1'b1;
    insn_word = w;
    @(negedge clk);
    insn_valid = 1'b0;
  endtask
  // Write-back pulse with address and data, gone again one cycle later
  task automatic wb(input logic [4:0] a, input logic [7:0] d);
    check({7'h00, we}, 8'h01);
    check({3'h0, waddr}, {3'h0, a});
    check(wdata, d);
    em[a] = d;
    @(negedge clk);
    check({7'h00, we}, 8'h00);
  endtask
  task automatic core;
    check(acc, ea);
    check({7'h00, zero}, {7'h00, ez});
  endtask
  // Literal XOR walks the accumulator to zero, so the flag is seen both ways
  task automatic lit_xor_case;
    for (int i = 0; i < 3; i++)
    begin
      run({4'hf, ks[i]});
      ea = ea ^ ks[i];
      ez = (ea == 8'h00);
      core();
    end
  endtask
  // Swap to the accumulator runs with zero set, which must survive it
  task automatic swap_case;
    run(12'h383);
    ea = {em[3][3:0], em[3][7:4]};
    core();
    check({7'h00, we}, 8'h00);
    run(12'h3a9);
    wb(5'h09, {em[9][3:0], em[9][7:4]});
    core();
  endtask
  task automatic reg_xor_case;
    run(12'h187);
    ea = ea ^ em[7];
    ez = (ea == 8'h00);
    core();
    run(12'h1ac);
    ez = ((ea ^ em[12]) == 8'h00);
    wb(5'h0c, ea ^ em[12]);
    core();
  endtask
  // Operand 4 is ignored; 5, 6 and 7 each take a different accumulator value
  task automatic dir_case;
    run(12'h004);
    check(da & db & dc, 8'hff);
    for (int i = 5; i < 8; i++)
    begin
      run({4'hf, 8'(i * 16)});
      ea = ea ^ 8'(i * 16);
      ez = (ea == 8'h00);
      run(12'(i));
      check(i == 5 ? da : i == 6 ? db : dc, ea);
      core();
    end
  endtask
  task automatic tally_and_finish;
    $display("Checks %0d, mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence after ten cycles of reset
  initial
  begin
    for (int i = 0; i < 32; i++) em[i] = 8'(i * 37 + 5);
    ea = 8'h00;
    ez = 1'b0;
    repeat (10) @(negedge clk);
    reset_n = 1'b1;
    core();
    check(da & db & dc, 8'hff);
    lit_xor_case();
    swap_case();
    reg_xor_case();
    dir_case();
    tally_and_finish();
  end
  // A hang is cut short and counted as a mismatch
  initial
  begin
    repeat (2000) @(posedge clk);
    bad_count++;
    tally_and_finish();
  end
endmodule // swap_xor_dirload_decode_tb_top
